//--- shared/rodi_params.svh
`ifndef RODI_PARAMS_SVH
`define RODI_PARAMS_SVH
`define RODI_REG_ACC 4'hd
`define RODI_REG_FP 4'he
`define RODI_REG_SP 4'hf
`define RODI_SPC_TBR 4'h0
`define RODI_SPC_RP 4'h1
`define RODI_SPC_SSP 4'h2
`define RODI_SPC_USP 4'h3
`define RODI_SPC_MDH 4'h4
`define RODI_SPC_MDL 4'h5
`define RODI_OP_LDI8 4'hc
`define RODI_OP_LDI20 8'h9b
`define RODI_OP_LDSP 8'h03
`define RODI_OP_STSP 8'h13
`define RODI_OP_LDFPW 4'h2
`define RODI_OP_LDFPH 4'h4
`define RODI_OP_LDFPB 4'h6
`define RODI_OP_STFPW 4'h3
`define RODI_OP_STFPH 4'h5
`define RODI_OP_STFPB 4'h7
`define RODI_OP_DIRH 8'h08
`define RODI_OP_BCC 4'he
`define RODI_OP_CALL 5'h1a
`define RODI_OP_E97 8'h97
`define RODI_OP_E9F 8'h9f
`define RODI_OP_E07 8'h07
`define RODI_OP_E17 8'h17
`define RODI_SUB_DIV1 4'h6
`define RODI_LOAD_STALL 2'd1
`define RODI_DIV_STALL 2'd1
`endif

//--- shared/rodi_pkg.sv
package rodi_pkg;
	typedef enum logic [2:0] {
		FMT_A = 3'd0, FMT_B = 3'd1, FMT_C = 3'd2, FMT_CP = 3'd3, FMT_D = 3'd4, FMT_E = 3'd5
	} rodi_fmt_t;
	typedef enum logic [1:0] {SZ_WORD = 2'd0, SZ_HALF = 2'd1, SZ_BYTE = 2'd2} rodi_size_t;
	typedef struct packed {
		rodi_fmt_t fmt;
		logic [7:0] opcode;
		logic [3:0] srcRegField;
		logic [3:0] destRegField;
		logic [3:0] subOp;
		logic [31:0] imm;
		logic isLoad;
		logic isStore;
		logic isRmw;
		logic usesSp;
		logic isDivStep;
		logic readsMuldiv;
		logic postIncAcc;
		logic spcValid;
		logic [2:0] spcSel;
	} rodi_dec_t;
	typedef struct packed {
		logic valid;
		logic [3:0] loadDest;
		logic spHazard;
		logic divStep;
	} rodi_prev_t;
endpackage : rodi_pkg

//--- hw/rodi_field_decode.sv
`timescale 1ns/10ps
`include "rodi_params.svh"
module rodi_field_decode (
	input wire logic [15:0] instrWord, // fetched instruction
	output rodi_pkg::rodi_dec_t dec // decoded fields
);
	logic [7:0] op8;
	logic [3:0] op4;
	assign op8 = instrWord[15:8];
	assign op4 = instrWord[15:12];
	always_comb begin
		dec = '0;
		dec.opcode = op8;
		dec.srcRegField = instrWord[7:4];
		dec.destRegField = instrWord[3:0];
		dec.subOp = instrWord[7:4];
		dec.fmt = rodi_pkg::FMT_A;
		if (op4 == `RODI_OP_LDI8) begin
			dec.fmt = rodi_pkg::FMT_B;
			dec.imm = {24'h000000, instrWord[11:4]};
		end else if (op4 >= `RODI_OP_LDFPW && op4 <= `RODI_OP_STFPB) begin
			dec.fmt = rodi_pkg::FMT_B;
			dec.isLoad = ~op4[0];
			dec.isStore = op4[0];
			if (op4[3:1] == 3'd1)
				dec.imm = {{22{instrWord[11]}}, instrWord[11:4], 2'b00};
			else if (op4[3:1] == 3'd2)
				dec.imm = {{23{instrWord[11]}}, instrWord[11:4], 1'b0};
			else
				dec.imm = {{24{instrWord[11]}}, instrWord[11:4]};
		end else if (op4 == `RODI_OP_BCC) begin
			dec.fmt = rodi_pkg::FMT_D;
			dec.imm = {{23{instrWord[7]}}, instrWord[7:0], 1'b0};
		end else if (instrWord[15:11] == `RODI_OP_CALL) begin
			dec.fmt = rodi_pkg::FMT_D;
			dec.imm = {{20{instrWord[10]}}, instrWord[10:0], 1'b0};
		end else if (op8 == `RODI_OP_LDSP || op8 == `RODI_OP_STSP) begin
			dec.fmt = rodi_pkg::FMT_C;
			dec.isLoad = (op8 == `RODI_OP_LDSP);
			dec.isStore = (op8 == `RODI_OP_STSP);
			dec.usesSp = 1'b1;
			dec.imm = {26'h0, instrWord[7:4], 2'b00};
		end else if (op8 == `RODI_OP_LDI20) begin
			dec.fmt = rodi_pkg::FMT_C;
			dec.imm = {12'h000, instrWord[7:4], 16'h0000}; // upper nibble; rest follows
		end else if (op8[7:4] == 4'ha || op8[7:4] == 4'hb) begin
			dec.fmt = op8[2] ? rodi_pkg::FMT_A : rodi_pkg::FMT_CP;
			if (!op8[2])
				dec.imm = op8[0] ? {27'h0, op8[0], instrWord[7:4]}
					: {{27{instrWord[8]}}, instrWord[8:4]};
			dec.readsMuldiv = 1'b0;
		end else if (op8[7:4] == 4'h0 && op8[3:0] < 4'h7) begin
			dec.fmt = rodi_pkg::FMT_A;
			dec.isLoad = 1'b1;
			dec.postIncAcc = (op8[1:0] != 2'b00) ? 1'b0 : (op8[2] == 1'b0);
		end else if (op8[7:4] == 4'h1 && op8[3:0] < 4'h7) begin
			dec.isStore = 1'b1;
			dec.postIncAcc = (op8[2] == 1'b0);
		end else if (op8[7:3] == 5'b10000 || op8[7:4] == 4'h9 && op8[2]) begin
			dec.isRmw = 1'b1;
		end else if (op8[7:4] == 4'h0 && op8[3:0] == 4'h8) begin
			dec.fmt = rodi_pkg::FMT_D;
			dec.isLoad = 1'b1;
			dec.imm = {24'h0, instrWord[7:0]};
		end else if (op8[7:4] == 4'h0 && op8[3:0] == 4'h9) begin
			dec.fmt = rodi_pkg::FMT_D;
			dec.isLoad = 1'b1;
			dec.imm = {23'h0, instrWord[7:0], 1'b0};
		end else if (op8[7:4] == 4'h0 && op8[3:0] == 4'ha) begin
			dec.fmt = rodi_pkg::FMT_D;
			dec.isLoad = 1'b1;
			dec.imm = {22'h0, instrWord[7:0], 2'b00};
		end
		if (op8 == `RODI_OP_E97 || op8 == `RODI_OP_E9F || op8 == `RODI_OP_E07
			|| op8 == `RODI_OP_E17) begin
			dec.fmt = rodi_pkg::FMT_E;
			dec.isDivStep = (op8 == `RODI_OP_E97) && (instrWord[7:4] == `RODI_SUB_DIV1);
			if ((op8 == `RODI_OP_E07 || op8 == `RODI_OP_E17) && instrWord[7:4] == 4'h8) begin
				dec.spcValid = (instrWord[3:0] <= `RODI_SPC_MDL);
				dec.spcSel = instrWord[2:0];
				dec.readsMuldiv = (instrWord[3:0] == `RODI_SPC_MDH)
					|| (instrWord[3:0] == `RODI_SPC_MDL);
				dec.usesSp = 1'b1;
			end
			if (op8 == `RODI_OP_E07)
				dec.isLoad = 1'b1;
			if (op8 == `RODI_OP_E17)
				dec.isStore = 1'b1;
			if (op8 == `RODI_OP_E07 || op8 == `RODI_OP_E17)
				dec.usesSp = 1'b1;
		end
		if (instrWord[3:0] == `RODI_REG_SP || instrWord[7:4] == `RODI_REG_SP
			&& dec.fmt == rodi_pkg::FMT_A)
			dec.usesSp = 1'b1;
	end
endmodule : rodi_field_decode

//--- hw/rodi_stall_ctrl.sv
`timescale 1ns/10ps
`include "rodi_params.svh"
module rodi_stall_ctrl (
	input wire logic ref_clk, // core clock
	input wire logic srst, // sync reset
	input wire logic [1:0] stallNeed, // extra cycles demanded
	input wire logic startReq, // hazard detected this issue
	output logic busy // stall in progress
);
	typedef struct packed {
		logic [1:0] remain;
	} rodi_stall_st_t;
	rodi_stall_st_t st_reg, st_next;
	always_comb begin
		st_next = st_reg;
		if (st_reg.remain != 2'd0)
			st_next.remain = st_reg.remain - 2'd1;
		else if (startReq)
			st_next.remain = stallNeed;
	end
	always_ff @(posedge ref_clk) begin
		if (srst)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end
	assign busy = (st_reg.remain != 2'd0);
endmodule : rodi_stall_ctrl

//--- hw/rodi_operand_decode.sv
`timescale 1ns/10ps
`include "rodi_params.svh"
module rodi_operand_decode #(
	parameter int SP_STALL = 2 // interlock cycles after stack pointer hazards
) (
	input wire logic ref_clk, // core clock
	input wire logic srst, // sync reset
	input wire logic instrValid, // fetch offers a word
	input wire logic [15:0] instrWord, // instruction word
	input wire logic memReady, // external ready
	output logic instrTake_reg, // word accepted this cycle
	output rodi_pkg::rodi_dec_t decOut_reg, // decoded operands
	output logic decValid_reg, // decoded operands valid
	output logic stall_reg, // pipeline held
	output logic memReq_reg // memory access active
);
	initial begin
		if (SP_STALL < 1 || SP_STALL > 2)
			$error("SP_STALL out of range");
	end
	typedef enum logic [2:0] {
		ST_ISSUE = 3'b001, ST_MEM = 3'b010, ST_HOLD = 3'b100
	} rodi_state_t;
	typedef struct packed {
		rodi_state_t state;
		rodi_pkg::rodi_prev_t prev;
		rodi_pkg::rodi_dec_t dec;
		logic decValid;
		logic take;
		logic stall;
		logic memReq;
		logic prevLoad;
	} rodi_top_st_t;
	rodi_top_st_t st_reg, st_next;
	rodi_pkg::rodi_dec_t curDec;
	logic stallBusy;
	logic hazard;
	logic [1:0] need;
	logic [1:0] holdLen;
	// the refusing edge is itself the first stall cycle
	assign holdLen = need - 2'd1;
	rodi_field_decode uDec (
		.instrWord(instrWord),
		.dec(curDec)
	);
	rodi_stall_ctrl uStall (
		.ref_clk(ref_clk),
		.srst(srst),
		.stallNeed(holdLen),
		.startReq(hazard),
		.busy(stallBusy)
	);
	always_comb begin
		need = 2'd0;
		if (st_reg.prev.valid && instrValid) begin
			if (st_reg.prevLoad) begin
				if (curDec.srcRegField == st_reg.prev.loadDest
					|| curDec.destRegField == st_reg.prev.loadDest)
					need = `RODI_LOAD_STALL;
			end
			if (st_reg.prev.spHazard && (curDec.usesSp || curDec.fmt == rodi_pkg::FMT_A))
				need = 2'(SP_STALL);
			if (st_reg.prev.divStep && curDec.readsMuldiv)
				need = `RODI_DIV_STALL;
		end
	end
	assign hazard = (need != 2'd0) && (st_reg.state == ST_ISSUE);
	always_comb begin
		logic doTake;
		doTake = 1'b0;
		st_next = st_reg;
		st_next.take = 1'b0;
		st_next.decValid = 1'b0;
		case (st_reg.state)
			ST_ISSUE: begin
				st_next.memReq = 1'b0;
				st_next.stall = 1'b0;
				if (hazard) begin
					st_next.state = ST_HOLD;
					st_next.stall = 1'b1;
				end else if (instrValid && !stallBusy)
					doTake = 1'b1;
			end
			ST_MEM: begin
				if (memReady) begin
					st_next.memReq = 1'b0;
					st_next.state = ST_ISSUE;
				end else
					st_next.stall = 1'b1;
			end
			ST_HOLD: begin
				st_next.stall = 1'b1;
				// held word goes straight in when the count ends, no extra cycle
				if (!stallBusy && instrValid) begin
					st_next.stall = 1'b0;
					doTake = 1'b1;
				end
			end
			default: st_next.state = ST_ISSUE;
		endcase
		if (doTake) begin
			st_next.state = ST_ISSUE;
			st_next.take = 1'b1;
			st_next.dec = curDec;
			st_next.decValid = 1'b1;
			st_next.prev.valid = 1'b1;
			st_next.prevLoad = curDec.isLoad;
			st_next.prev.loadDest = curDec.destRegField;
			st_next.prev.spHazard = curDec.usesSp;
			st_next.prev.divStep = curDec.isDivStep;
			if (curDec.isLoad || curDec.isStore || curDec.isRmw) begin
				st_next.state = ST_MEM;
				st_next.memReq = 1'b1;
			end
		end
	end
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st_reg <= '0;
			st_reg.state <= ST_ISSUE;
		end else
			st_reg <= st_next;
	end
	assign instrTake_reg = st_reg.take;
	assign decOut_reg = st_reg.dec;
	assign decValid_reg = st_reg.decValid;
	assign stall_reg = st_reg.stall;
	assign memReq_reg = st_reg.memReq;
endmodule : rodi_operand_decode

//--- testbench/rodi_operand_decode_properties.sv
`timescale 1ns/10ps
`include "rodi_params.svh"
module rodi_checker (
	input wire logic ref_clk, // core clock
	input wire logic srst, // sync reset
	input wire logic instrValid, // fetch offer
	input wire logic [15:0] instrWord, // offered word
	input wire logic memReady, // external ready
	input wire logic instrTake_reg, // word taken
	input wire rodi_pkg::rodi_dec_t decOut_reg, // decoded fields
	input wire logic decValid_reg, // decode valid
	input wire logic stall_reg, // pipeline held
	input wire logic memReq_reg // access busy
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	// word seen at the take edge, kept to judge the decode one cycle later
	logic [15:0] w;
	always_ff @(posedge ref_clk) begin
		w <= instrWord;
	end
	AST_VALID_TAKE: assert property (decValid_reg |-> instrTake_reg)
		else $error("decode valid without take");
	AST_TAKE_OFFER: assert property (instrTake_reg |-> $past(instrValid))
		else $error("take without offer");
	AST_LDI8_ZERO: assert property (decValid_reg && w[15:12] == `RODI_OP_LDI8 |->
		decOut_reg.imm == {24'h0, w[11:4]} && decOut_reg.destRegField == w[3:0])
		else $error("8-bit immediate not zero filled");
	AST_FPW_SCALE: assert property (decValid_reg &&
		w[15:12] inside {`RODI_OP_LDFPW, `RODI_OP_STFPW} |->
		decOut_reg.imm == {{22{w[11]}}, w[11:4], 2'h0}) else $error("word frame offset");
	AST_FPH_SCALE: assert property (decValid_reg &&
		w[15:12] inside {`RODI_OP_LDFPH, `RODI_OP_STFPH} |->
		decOut_reg.imm == {{23{w[11]}}, w[11:4], 1'h0}) else $error("half frame offset");
	AST_FPB_SCALE: assert property (decValid_reg &&
		w[15:12] inside {`RODI_OP_LDFPB, `RODI_OP_STFPB} |->
		decOut_reg.imm == {{24{w[11]}}, w[11:4]}) else $error("byte frame offset");
	AST_SP_OFF: assert property (decValid_reg &&
		w[15:8] inside {`RODI_OP_LDSP, `RODI_OP_STSP} |->
		decOut_reg.imm == {26'h0, w[7:4], 2'h0}) else $error("stack offset");
	AST_MEM_HOLD: assert property (memReq_reg && !memReady |=> memReq_reg)
		else $error("access ended without ready");
	AST_MEM_END: assert property (memReq_reg && memReady |=> !memReq_reg)
		else $error("access outlived ready");
	AST_LOAD_REQ: assert property (decValid_reg && decOut_reg.isLoad |-> memReq_reg)
		else $error("load without access");
endmodule : rodi_checker
bind rodi_operand_decode rodi_checker rodi_checker_i (.ref_clk(ref_clk), .srst(srst),
	.instrValid(instrValid), .instrWord(instrWord), .memReady(memReady),
	.instrTake_reg(instrTake_reg), .decOut_reg(decOut_reg), .decValid_reg(decValid_reg),
	.stall_reg(stall_reg), .memReq_reg(memReq_reg));

//--- testbench/rodi_mem_model.sv
`timescale 1ns/10ps
module rodi_mem_model (
	input wire logic ref_clk, // core clock
	input wire logic srst, // sync reset
	input wire logic memReq, // access pending
	input wire logic [3:0] lat, // wait states
	output logic memReady // access done
);
	logic [3:0] waitCnt_reg;
	always @(posedge ref_clk) begin
		if (srst || !memReq || memReady) begin
			waitCnt_reg <= 4'h0;
			memReady <= 1'b0;
		end else begin
			waitCnt_reg <= waitCnt_reg + 4'h1;
			memReady <= (waitCnt_reg == lat);
		end
	end
endmodule : rodi_mem_model

//--- testbench/rodi_operand_decode_tb.sv
`timescale 1ns/10ps
`include "rodi_params.svh"
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin n_fail++; \
	$display("mismatch %s exp %0h got %0h", n, e, a); end end
module rodi_operand_decode_tb;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic instrValid = 1'b0;
	logic [15:0] instrWord = 16'h0000;
	logic [3:0] lat = 4'h2;
	logic memReady, instrTake_reg, decValid_reg, stall_reg, memReq_reg;
	rodi_pkg::rodi_dec_t decOut_reg;
	int n_fail = 0;
	int cmp_count = 0;
	always #12.5 ref_clk = ~ref_clk;
	rodi_operand_decode rodi_operand_decode_i (.ref_clk(ref_clk), .srst(srst),
		.instrValid(instrValid), .instrWord(instrWord), .memReady(memReady),
		.instrTake_reg(instrTake_reg), .decOut_reg(decOut_reg), .decValid_reg(decValid_reg),
		.stall_reg(stall_reg), .memReq_reg(memReq_reg));
	rodi_mem_model rodi_mem_model_i (.ref_clk(ref_clk), .srst(srst), .memReq(memReq_reg),
		.lat(lat), .memReady(memReady));
	task automatic report_and_stop;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : report_and_stop
	// fetch holds the word until the take shows; c counts cycles from the offer
	task automatic issue(input logic [15:0] w, output int c);
		c = 0;
		@(posedge ref_clk);
		instrValid <= 1'b1;
		instrWord <= w;
		#1;
		c++;
		do begin
			@(posedge ref_clk);
			#1;
			c++;
		end while (instrTake_reg !== 1'b1 && c < 40);
		`CHK("decValid", 1'b1, decValid_reg)
	endtask : issue
	task automatic idle;
		@(posedge ref_clk);
		instrValid <= 1'b0;
		repeat (8) @(posedge ref_clk);
		#1;
	endtask : idle
	task automatic t_imm;
		int c;
		logic [7:0] vals [3] = '{8'h00, 8'h80, 8'hff};
		for (int k = 0; k < 3; k++) begin
			issue({`RODI_OP_LDI8, vals[k], 4'h1}, c);
			`CHK("imm8", {24'h0, vals[k]}, decOut_reg.imm)
			`CHK("dest", 4'h1, decOut_reg.destRegField)
		end
		idle();
	endtask : t_imm
	task automatic t_fp;
		int c;
		logic [3:0] ops [3] = '{`RODI_OP_LDFPW, `RODI_OP_LDFPH, `RODI_OP_LDFPB};
		logic [31:0] expN [3] = '{32'hfffffe00, 32'hffffff00, 32'hffffff80};
		logic [31:0] expP [3] = '{32'h000001fc, 32'h000000fe, 32'h0000007f};
		lat = 4'h3;
		for (int k = 0; k < 3; k++) begin
			issue({ops[k], 8'h80, 4'h4}, c);
			`CHK("fpneg", expN[k], decOut_reg.imm)
			`CHK("memreq", 1'b1, memReq_reg)
			issue({ops[k], 8'h7f, 4'h4}, c);
			`CHK("fppos", expP[k], decOut_reg.imm)
			`CHK("waitheld", 1'b1, c >= 5)
		end
		idle();
	endtask : t_fp
	// gap to the next take must grow by one when it uses the loaded register
	task automatic t_stall;
		int c;
		int c0;
		int c1;
		lat = 4'h2;
		issue({`RODI_OP_LDSP, 4'hf, 4'h2}, c);
		`CHK("spoff", 32'h0000003c, decOut_reg.imm)
		issue({`RODI_OP_LDI8, 8'h05, 4'h3}, c0);
		idle();
		issue({`RODI_OP_LDSP, 4'h1, 4'h2}, c);
		`CHK("spoff", 32'h00000004, decOut_reg.imm)
		issue({`RODI_OP_LDI8, 8'h05, 4'h2}, c1);
		idle();
		`CHK("loaduse", c0 + 1, c1)
	endtask : t_stall
	initial begin
		repeat (5000) @(posedge ref_clk);
		n_fail++;
		$display("mismatch watchdog exp done got hang");
		report_and_stop();
	end
	initial begin
		repeat (10) @(posedge ref_clk);
		srst <= 1'b0;
		t_imm();
		t_fp();
		t_stall();
		report_and_stop();
	end
endmodule : rodi_operand_decode_tb
